// ===== cms_clock_mode_select.sv
// clock operating-mode selection with freq_ratio_register over axi4-lite
//
// The implementer's own choices: the AXI4-Lite register port and the placing of the registers.
`default_nettype none
module cms_clock_mode_select
  import cms_pkg::*;
#(
  parameter int unsigned STALL_CYCLES = cms_pkg::CMS_STALL_CYCLES
) (
  input  wire logic                  CLK,
  input  wire logic                  RST,
  input  wire cms_pkg::cms_axi_req_t AXI_REQ,
  output var  cms_pkg::cms_axi_rsp_t AXI_RSP,
  input  wire logic                  MODE_PIN_0,
  input  wire logic                  MODE_PIN_1,
  input  wire logic                  MODE_PIN_2,
  input  wire logic                  CRYSTAL_SELECT_OR_PAUSE_REQ,
  input  wire logic                  EBUS_CLK_SRC,
  input  wire logic                  BUS_CLOCK_PIN_I,
  output logic                       BUS_CLOCK_PIN_O,
  output logic                       BUS_CLOCK_PIN_OE,
  output logic                       PHASE_PLL_RUN,
  output logic                       MULT_PLL_RUN,
  output logic                       PHASE_REF_FROM_PIN,
  output logic                       QUARTER_LEAD,
  output logic                       QUARTER_LAG,
  output logic                       OSC_CRYSTAL_EN,
  output logic                       OSC_EXT_IN_EN,
  output logic                       PIN_CLOCK_DIRECT,
  output logic                       PAUSE_REQ,
  output logic [3:0]                 FREQ_RATIO,
  output logic [2:0]                 MODE,
  output logic                       MODE_INVALID,
  output logic                       PIN_CLOCK_STOPPED
);
  import cms_pkg::*;

  if (STALL_CYCLES < 1 || STALL_CYCLES >= (1 << CMS_CNT_W)) begin : g_bad_stall
    $error("STALL_CYCLES out of range");
  end

  typedef struct packed {
    cms_mode_t             mode;
    logic [7:0]            frr;
    logic                  aw_pend;
    logic [CMS_ADDR_W-1:0] awaddr;
    logic                  w_pend;
    logic [7:0]            wbyte;
    logic                  wbyte_en;
    logic                  bvalid;
    logic [1:0]            bresp;
    logic                  rvalid;
    logic [CMS_DATA_W-1:0] rdata;
    logic [1:0]            rresp;
    logic                  pin_prev;
    logic [CMS_CNT_W-1:0]  idle_cnt;
    logic                  pin_stopped;
  } cms_state_t;

  cms_state_t s_reg;
  cms_state_t s_next;

  ////////////////////////////////////////////////////////////////////////////
  // mode decoding helpers

  function automatic logic [7:0] frr_reset(input cms_mode_t m);
    case (m)
      CMS_MODE0, CMS_MODE1: frr_reset = CMS_FRR_RST_M01;
      CMS_MODE2:            frr_reset = CMS_FRR_RST_M2;
      CMS_MODE3:            frr_reset = CMS_FRR_RST_M3;
      CMS_MODE4, CMS_MODE5: frr_reset = CMS_FRR_RST_M45;
      CMS_MODE6:            frr_reset = CMS_FRR_RST_M6;
      default:              frr_reset = CMS_FRR_RST_BAD;
    endcase
  endfunction

  // bits fixed at 1 where the resource is absent
  function automatic logic [7:0] frr_view(input cms_mode_t m, input logic [7:0] r);
    logic [7:0] v;
    v = r;
    v[CMS_RSVD_BIT] = 1'b0;
    if (m[2]) begin
      v[CMS_MULT_DIS_BIT] = 1'b1;
      v[CMS_FLOAT_BIT]    = 1'b1;
    end
    if (m == CMS_MODE2 || m == CMS_MODE3 || m == CMS_MODE6 || m == CMS_MODE7) begin
      v[CMS_PHASE_DIS_BIT] = 1'b1;
    end
    if (m == CMS_MODE3) begin
      v[CMS_FLOAT_BIT] = 1'b1;
    end
    frr_view = v;
  endfunction

  function automatic logic pin_is_input(input cms_mode_t m);
    pin_is_input = m[2];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // next state

  logic [7:0] frr_eff;
  logic [2:0] mode_pins;
  logic       aw_hs;
  logic       w_hs;
  logic       ar_hs;
  logic       pin_edge;

  always_comb begin
    mode_pins = {MODE_PIN_2, MODE_PIN_1, MODE_PIN_0};
    frr_eff   = frr_view(s_reg.mode, s_reg.frr);
    aw_hs     = AXI_REQ.awvalid && !s_reg.aw_pend && !s_reg.bvalid;
    w_hs      = AXI_REQ.wvalid && !s_reg.w_pend && !s_reg.bvalid;
    ar_hs     = AXI_REQ.arvalid && !s_reg.rvalid;
    pin_edge  = BUS_CLOCK_PIN_I != s_reg.pin_prev;
    s_next    = s_reg;
    if (RST) begin
      // mode latched at reset; pins must then stay put
      s_next          = '0;
      s_next.mode     = cms_mode_t'(mode_pins);
      s_next.frr      = frr_reset(cms_mode_t'(mode_pins));
      s_next.pin_prev = BUS_CLOCK_PIN_I;
    end else begin
      // write channel
      if (aw_hs) begin
        s_next.aw_pend = 1'b1;
        s_next.awaddr  = AXI_REQ.awaddr;
      end
      if (w_hs) begin
        s_next.w_pend   = 1'b1;
        s_next.wbyte    = AXI_REQ.wdata[7:0];
        s_next.wbyte_en = AXI_REQ.wstrb[0];
      end
      if (s_reg.aw_pend && s_reg.w_pend) begin
        s_next.aw_pend = 1'b0;
        s_next.w_pend  = 1'b0;
        s_next.bvalid  = 1'b1;
        s_next.bresp   = CMS_RESP_OKAY;
        if (s_reg.awaddr == CMS_FRR_OFF) begin
          if (s_reg.wbyte_en) begin
            // frequency ratio open in every mode
            s_next.frr[CMS_FR_LSB +: CMS_FR_W] =
              s_reg.wbyte[CMS_FR_LSB +: CMS_FR_W];
            if (!s_reg.mode[2]) begin
              s_next.frr[CMS_MULT_DIS_BIT] = s_reg.wbyte[CMS_MULT_DIS_BIT];
              s_next.frr[CMS_FLOAT_BIT]    = s_reg.wbyte[CMS_FLOAT_BIT];
            end
            if (s_reg.mode == CMS_MODE0 || s_reg.mode == CMS_MODE1 ||
                s_reg.mode == CMS_MODE4 || s_reg.mode == CMS_MODE5) begin
              s_next.frr[CMS_PHASE_DIS_BIT] = s_reg.wbyte[CMS_PHASE_DIS_BIT];
            end
          end
        end else if (s_reg.awaddr != CMS_STAT_OFF) begin
          s_next.bresp = CMS_RESP_SLVERR;
        end
      end
      if (s_reg.bvalid && AXI_REQ.bready) begin
        s_next.bvalid = 1'b0;
      end
      // read channel
      if (s_reg.rvalid && AXI_REQ.rready) begin
        s_next.rvalid = 1'b0;
      end
      if (ar_hs) begin
        s_next.rvalid = 1'b1;
        s_next.rresp  = CMS_RESP_OKAY;
        s_next.rdata  = '0;
        case (AXI_REQ.araddr)
          CMS_FRR_OFF: begin
            s_next.rdata[7:0] = frr_eff;
          end
          CMS_STAT_OFF: begin
            s_next.rdata[CMS_ST_MODE_LSB +: 3] = s_reg.mode;
            s_next.rdata[CMS_ST_BAD_BIT]       = MODE_INVALID;
            s_next.rdata[CMS_ST_PHASE_BIT]     = PHASE_PLL_RUN;
            s_next.rdata[CMS_ST_MULT_BIT]      = MULT_PLL_RUN;
            s_next.rdata[CMS_ST_DRIVE_BIT]     = BUS_CLOCK_PIN_OE;
            s_next.rdata[CMS_ST_STOP_BIT]      = s_reg.pin_stopped;
            s_next.rdata[CMS_ST_PAUSE_BIT]     = PAUSE_REQ;
          end
          default: begin
            s_next.rresp = CMS_RESP_SLVERR;
          end
        endcase
      end
      // pin clock may stall or change rate when it is an input
      s_next.pin_prev = BUS_CLOCK_PIN_I;
      if (!pin_is_input(s_reg.mode) || pin_edge) begin
        s_next.idle_cnt    = '0;
        s_next.pin_stopped = 1'b0;
      end else if (s_reg.idle_cnt == CMS_CNT_W'(STALL_CYCLES - 1)) begin
        s_next.pin_stopped = 1'b1;
      end else begin
        s_next.idle_cnt = s_reg.idle_cnt + CMS_CNT_W'(1);
      end
    end
  end

  always_ff @(posedge CLK) begin
    s_reg <= s_next;
  end

  ////////////////////////////////////////////////////////////////////////////
  // clock tree controls

  logic phase_ok;
  logic mult_ok;

  always_comb begin
    MODE         = s_reg.mode;
    MODE_INVALID = s_reg.mode == CMS_MODE7;
    FREQ_RATIO   = frr_eff[CMS_FR_LSB +: CMS_FR_W];
    phase_ok     = 1'b0;
    mult_ok      = 1'b0;
    case (s_reg.mode)
      CMS_MODE0, CMS_MODE1: begin
        phase_ok = 1'b1;
        mult_ok  = 1'b1;
      end
      CMS_MODE2, CMS_MODE3: begin
        mult_ok = 1'b1;
      end
      CMS_MODE4, CMS_MODE5: begin
        phase_ok = 1'b1;
      end
      default: begin
        phase_ok = 1'b0;
        mult_ok  = 1'b0;
      end
    endcase
    PHASE_PLL_RUN      = phase_ok && !frr_eff[CMS_PHASE_DIS_BIT];
    MULT_PLL_RUN       = mult_ok && !frr_eff[CMS_MULT_DIS_BIT];
    PHASE_REF_FROM_PIN = PHASE_PLL_RUN && pin_is_input(s_reg.mode);
    QUARTER_LEAD       = s_reg.mode == CMS_MODE1 && PHASE_PLL_RUN;
    QUARTER_LAG        = s_reg.mode == CMS_MODE5 && PHASE_PLL_RUN;
    PIN_CLOCK_DIRECT   = s_reg.mode == CMS_MODE6;
    // pin drives in modes 0-2 unless floated
    BUS_CLOCK_PIN_OE   = !s_reg.mode[2] && !frr_eff[CMS_FLOAT_BIT];
    BUS_CLOCK_PIN_O    = BUS_CLOCK_PIN_OE && EBUS_CLK_SRC;
    OSC_CRYSTAL_EN     = !s_reg.mode[2] && CRYSTAL_SELECT_OR_PAUSE_REQ;
    OSC_EXT_IN_EN      = !s_reg.mode[2] && !CRYSTAL_SELECT_OR_PAUSE_REQ;
    PAUSE_REQ          = pin_is_input(s_reg.mode) && CRYSTAL_SELECT_OR_PAUSE_REQ;
    PIN_CLOCK_STOPPED  = s_reg.pin_stopped;
  end

  ////////////////////////////////////////////////////////////////////////////
  // axi answers

  always_comb begin
    AXI_RSP         = '0;
    AXI_RSP.awready = !s_reg.aw_pend && !s_reg.bvalid;
    AXI_RSP.wready  = !s_reg.w_pend && !s_reg.bvalid;
    AXI_RSP.bvalid  = s_reg.bvalid;
    AXI_RSP.bresp   = s_reg.bresp;
    AXI_RSP.arready = !s_reg.rvalid;
    AXI_RSP.rvalid  = s_reg.rvalid;
    AXI_RSP.rdata   = s_reg.rdata;
    AXI_RSP.rresp   = s_reg.rresp;
  end
endmodule
`default_nettype wire

// ===== cms_pkg.sv
// shared constants and carrier types for the clock mode selector
`default_nettype none
package cms_pkg;
  localparam int unsigned CMS_ADDR_W = 8;
  localparam int unsigned CMS_DATA_W = 32;
  // register byte offsets
  localparam logic [CMS_ADDR_W-1:0] CMS_FRR_OFF  = 8'h90;
  localparam logic [CMS_ADDR_W-1:0] CMS_STAT_OFF = 8'h94;
  // freq_ratio_register field positions
  localparam int unsigned CMS_MULT_DIS_BIT  = 7;
  localparam int unsigned CMS_PHASE_DIS_BIT = 6;
  localparam int unsigned CMS_FLOAT_BIT     = 5;
  localparam int unsigned CMS_RSVD_BIT      = 4;
  localparam int unsigned CMS_FR_LSB        = 0;
  localparam int unsigned CMS_FR_W          = 4;
  // freq_ratio_register reset values per mode
  localparam logic [7:0] CMS_FRR_RST_M01 = 8'h00;
  localparam logic [7:0] CMS_FRR_RST_M2  = 8'h40;
  localparam logic [7:0] CMS_FRR_RST_M3  = 8'h60;
  localparam logic [7:0] CMS_FRR_RST_M45 = 8'hA6;
  localparam logic [7:0] CMS_FRR_RST_M6  = 8'hE0;
  localparam logic [7:0] CMS_FRR_RST_BAD = 8'hE0;
  // status register field positions
  localparam int unsigned CMS_ST_MODE_LSB   = 0;
  localparam int unsigned CMS_ST_BAD_BIT    = 3;
  localparam int unsigned CMS_ST_PHASE_BIT  = 4;
  localparam int unsigned CMS_ST_MULT_BIT   = 5;
  localparam int unsigned CMS_ST_DRIVE_BIT  = 6;
  localparam int unsigned CMS_ST_STOP_BIT   = 7;
  localparam int unsigned CMS_ST_PAUSE_BIT  = 8;
  // axi responses
  localparam logic [1:0] CMS_RESP_OKAY   = 2'h0;
  localparam logic [1:0] CMS_RESP_SLVERR = 2'h2;
  // pin clock stop detection
  localparam int unsigned CMS_STALL_NS     = 256;
  localparam int unsigned CMS_CLK_MHZ      = 250;
  localparam int unsigned CMS_STALL_CYCLES = (CMS_STALL_NS * CMS_CLK_MHZ) / 1000;
  localparam int unsigned CMS_CNT_W        = 16;

  typedef enum logic [2:0] {
    CMS_MODE0 = 3'b000,
    CMS_MODE1 = 3'b001,
    CMS_MODE2 = 3'b010,
    CMS_MODE3 = 3'b011,
    CMS_MODE4 = 3'b100,
    CMS_MODE5 = 3'b101,
    CMS_MODE6 = 3'b110,
    CMS_MODE7 = 3'b111
  } cms_mode_t;

  typedef struct packed {
    logic [CMS_ADDR_W-1:0]   awaddr;
    logic                    awvalid;
    logic [CMS_DATA_W-1:0]   wdata;
    logic [CMS_DATA_W/8-1:0] wstrb;
    logic                    wvalid;
    logic                    bready;
    logic [CMS_ADDR_W-1:0]   araddr;
    logic                    arvalid;
    logic                    rready;
  } cms_axi_req_t;

  typedef struct packed {
    logic                  awready;
    logic                  wready;
    logic [1:0]            bresp;
    logic                  bvalid;
    logic                  arready;
    logic [CMS_DATA_W-1:0] rdata;
    logic [1:0]            rresp;
    logic                  rvalid;
  } cms_axi_rsp_t;
endpackage
`default_nettype wire

// ===== cms_clock_mode_select_chk.sv
// port-level assertions for the clock mode selector
`default_nettype none
module cms_clock_mode_select_chk (
  input wire logic                  CLK,
  input wire logic                  RST,
  input wire cms_pkg::cms_axi_req_t AXI_REQ,
  input wire cms_pkg::cms_axi_rsp_t AXI_RSP,
  input wire logic                  MODE_PIN_0,
  input wire logic                  MODE_PIN_1,
  input wire logic                  MODE_PIN_2,
  input wire logic                  CRYSTAL_SELECT_OR_PAUSE_REQ,
  input wire logic                  EBUS_CLK_SRC,
  input wire logic                  BUS_CLOCK_PIN_O,
  input wire logic                  BUS_CLOCK_PIN_OE,
  input wire logic                  PHASE_PLL_RUN,
  input wire logic                  MULT_PLL_RUN,
  input wire logic                  QUARTER_LEAD,
  input wire logic                  QUARTER_LAG,
  input wire logic                  PAUSE_REQ,
  input wire logic [2:0]            MODE,
  input wire logic                  MODE_INVALID
);
  import cms_pkg::*;
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  ////////////////////////////////////////
  sequence both_taken_s;
    AXI_REQ.awvalid && AXI_RSP.awready && AXI_REQ.wvalid && AXI_RSP.wready;
  endsequence
  sequence resp_late_s;
    !AXI_RSP.bvalid ##1 AXI_RSP.bvalid;
  endsequence
  ////////////////////////////////////////
  mode_latch_a: assert property (disable iff (1'b0)
    RST |=> MODE == $past({MODE_PIN_2, MODE_PIN_1, MODE_PIN_0})) else $error("mode not latched");
  mode_hold_a: assert property (1'b1 |=> $stable(MODE))
    else $error("mode moved outside reset");
  mode_bad_a: assert property (MODE_INVALID == (MODE == CMS_MODE7))
    else $error("invalid flag wrong");
  pin_drive_a: assert property (BUS_CLOCK_PIN_OE |-> MODE < 3'h3 && BUS_CLOCK_PIN_O == EBUS_CLK_SRC)
    else $error("pin driven in wrong mode");
  no_mult_a: assert property (MODE[2] |-> !MULT_PLL_RUN && !BUS_CLOCK_PIN_OE)
    else $error("multiplying pll on in pin clock mode");
  no_phase_a: assert property (MODE inside {3'h2, 3'h3, 3'h6, 3'h7} |-> !PHASE_PLL_RUN)
    else $error("phase pll on in wrong mode");
  lead_a: assert property (QUARTER_LEAD == (MODE == CMS_MODE1 && PHASE_PLL_RUN))
    else $error("quarter lead wrong");
  lag_a: assert property (QUARTER_LAG == (MODE == CMS_MODE5 && PHASE_PLL_RUN))
    else $error("quarter lag wrong");
  pause_a: assert property (PAUSE_REQ == (MODE[2] && CRYSTAL_SELECT_OR_PAUSE_REQ))
    else $error("pause request wrong");
  wr_resp_a: assert property (both_taken_s |=> resp_late_s)
    else $error("write response timing wrong");
  rd_resp_a: assert property (AXI_REQ.arvalid && AXI_RSP.arready |=> AXI_RSP.rvalid)
    else $error("read response late");
endmodule
bind cms_clock_mode_select cms_clock_mode_select_chk i_chk (
  .CLK, .RST, .AXI_REQ, .AXI_RSP, .MODE_PIN_0, .MODE_PIN_1, .MODE_PIN_2,
  .CRYSTAL_SELECT_OR_PAUSE_REQ, .EBUS_CLK_SRC, .BUS_CLOCK_PIN_O, .BUS_CLOCK_PIN_OE,
  .PHASE_PLL_RUN, .MULT_PLL_RUN, .QUARTER_LEAD, .QUARTER_LAG, .PAUSE_REQ, .MODE, .MODE_INVALID);
`default_nettype wire

// ===== cms_board.sv
// board model: mode straps, select pin and external pin clock source
`default_nettype none
module cms_board (
  input  wire logic [2:0] mode,
  input  wire logic       sel,
  input  wire logic       run,
  input  wire logic       oe,
  input  wire logic       o,
  output logic [2:0]      md,
  output logic            ck_sel,
  output logic            pin
);
  timeunit 1ns;
  timeprecision 100ps;
  logic src = 1'b0;
  logic flt = 1'b0;
  // source clock may stop or run
  always #5 src = run ? ~src : src;
  // released pin with no pull keeps changing
  always #4 flt = ~flt;
  assign md = mode;
  assign ck_sel = sel;
  assign pin = oe ? o : (mode[2] ? src : flt);
endmodule
`default_nettype wire

// ===== cms_clock_mode_select_bench.sv
// self-checking bench for the clock mode selector
`default_nettype none
module cms_clock_mode_select_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import cms_pkg::*;
  logic CLK = 1'b0, RST = 1'b1, ebus = 1'b0, sel = 1'b0, run = 1'b1;
  logic [2:0] mode = 3'h0;
  cms_axi_req_t req = '0;
  cms_axi_rsp_t rsp;
  wire logic [2:0] md;
  wire logic cks, pin;
  logic po, oe, ph, mu, rf, ql, qg, cx, ex, dir, pr, stp;
  logic [3:0] fr;
  logic [31:0] q;
  logic [1:0] r;
  int failures = 0;
  int checked = 0;
  always #2 CLK = ~CLK;
  always @(posedge CLK) ebus <= ~ebus;
  ////////////////////////////////////////
  cms_clock_mode_select #(.STALL_CYCLES(4)) i_dut (
    .CLK, .RST, .AXI_REQ(req), .AXI_RSP(rsp), .MODE_PIN_0(md[0]), .MODE_PIN_1(md[1]),
    .MODE_PIN_2(md[2]), .CRYSTAL_SELECT_OR_PAUSE_REQ(cks), .EBUS_CLK_SRC(ebus),
    .BUS_CLOCK_PIN_I(pin), .BUS_CLOCK_PIN_O(po), .BUS_CLOCK_PIN_OE(oe), .PHASE_PLL_RUN(ph),
    .MULT_PLL_RUN(mu), .PHASE_REF_FROM_PIN(rf), .QUARTER_LEAD(ql), .QUARTER_LAG(qg),
    .OSC_CRYSTAL_EN(cx), .OSC_EXT_IN_EN(ex), .PIN_CLOCK_DIRECT(dir), .PAUSE_REQ(pr),
    .FREQ_RATIO(fr), .MODE(), .MODE_INVALID(), .PIN_CLOCK_STOPPED(stp));
  cms_board i_board (.mode, .sel, .run, .oe, .o(po), .md, .ck_sel(cks), .pin);
  ////////////////////////////////////////
  task automatic close_out;
    $display("mismatches %0d, comparisons %0d", failures, checked);
    if (failures == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      failures++;
      $display("wrong value at %0t: got %h want %h", $time, s, e);
    end
  endtask
  // one axi4-lite write (w=1) or read (w=0), bounded wait for the answer
  task automatic acc(input bit w, input logic [7:0] a, input logic [31:0] d);
    bit done;
    done = 1'b0;
    @(posedge CLK);
    req <= '{awaddr: a, awvalid: w, wdata: d, wstrb: 4'hF, wvalid: w, bready: w,
             araddr: a, arvalid: !w, rready: !w};
    for (int n = 0; n < 50 && !done; n++) begin
      @(posedge CLK);
      if (rsp.awready) req.awvalid <= 1'b0;
      if (rsp.wready) req.wvalid <= 1'b0;
      if (rsp.arready) req.arvalid <= 1'b0;
      if (w ? rsp.bvalid : rsp.rvalid) begin
        q = rsp.rdata;
        r = w ? rsp.bresp : rsp.rresp;
        req.bready <= 1'b0;
        req.rready <= 1'b0;
        done = 1'b1;
      end
    end
    if (!done) begin
      failures++;
      close_out();
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    acc(1'b0, a, 32'h0);
    chk(q, e);
  endtask
  task automatic boot(input logic [2:0] m);
    @(posedge CLK);
    RST <= 1'b1;
    mode <= m;
    repeat (16) @(posedge CLK);
    RST <= 1'b0;
    @(posedge CLK);
  endtask
  ////////////////////////////////////////
  task automatic t_modes;
    logic p, u, o;
    logic [7:0] e;
    for (int m = 0; m < 8; m++) begin
      boot(3'(m));
      p = m inside {0, 1, 4, 5};
      u = m < 4;
      o = m < 3;
      e = m == 2 ? 8'h40 : m == 3 ? 8'h60 : m > 5 ? 8'hE0 : m > 3 ? 8'hA6 : 8'h00;
      rd(CMS_FRR_OFF, 32'(e));
      rd(CMS_STAT_OFF, 32'({o, u, p, m == 7, 3'(m)}));
      chk(32'({ph, mu, oe, ql, qg, rf, dir, ex, cx}),
          32'({p, u, o, m == 1, m == 5, m == 4 || m == 5, m == 6, m < 4, 1'b0}));
    end
  endtask
  task automatic t_ctrl;
    sel <= 1'b1;
    boot(3'h0);
    chk(32'({cx, ex, pr}), 32'(3'b100));
    acc(1'b1, CMS_FRR_OFF, 32'hF4);
    chk(32'({ph, mu, oe, fr}), 32'(7'h04));
    rd(CMS_FRR_OFF, 32'hE4);
    acc(1'b1, CMS_FRR_OFF, 32'h00);
    chk(32'({ph, mu, oe, r}), 32'({3'b111, CMS_RESP_OKAY}));
    acc(1'b0, 8'h98, 32'h0);
    chk(32'(r), 32'(CMS_RESP_SLVERR));
  endtask
  task automatic t_m5;
    sel <= 1'b0;
    boot(3'h5);
    acc(1'b1, CMS_FRR_OFF, 32'h4A);
    rd(CMS_FRR_OFF, 32'hEA);
    chk(32'({ph, qg, rf, fr}), 32'(7'h0A));
    acc(1'b1, CMS_FRR_OFF, 32'h09);
    chk(32'({ph, qg, rf, fr}), 32'(7'h79));
    sel <= 1'b1;
    run <= 1'b0;
    for (int n = 0; n < 40 && !stp; n++) @(posedge CLK);
    chk(32'({pr, stp}), 32'(2'b11));
    run <= 1'b1;
    for (int n = 0; n < 40 && stp; n++) @(posedge CLK);
    chk(32'({ph, stp}), 32'(2'b10));
  endtask
  initial begin
    t_modes();
    t_ctrl();
    t_m5();
    close_out();
  end
endmodule
`default_nettype wire
